// File: bench/chan_fabric_model.sv
// Behavioural event channel fabric facing the event generator unit.
// Assumes one clock; the bench requests a channel pulse one cycle ahead.
`timescale 1ns/1ps
module chan_fabric_model (
   // Clock
   input wire logic sys_clk,
   // Bench request
   input wire logic send,
   input wire logic [7:0] send_ch,
   // Channel events
   output logic [evgen_pkg::NUM_CHANNELS-1:0] chan_in,
   input wire logic [evgen_pkg::NUM_CHANNELS-1:0] chan_out,
   // Observation
   output int pulse_count
);
   initial begin
      chan_in = '0;
      pulse_count = 0;
   end
   // Pulses last exactly one cycle so that a listener never fires twice.
   always @(posedge sys_clk) begin
      chan_in <= (send ? 256'h1 : 256'h0) << send_ch;
      pulse_count <= pulse_count + $countones(chan_out);
   end
endmodule // chan_fabric_model

// File: bench/test_event_generator_unit.sv
// Self-checking bench for the event generator unit against a bench model.
// Assumes the package and the channel fabric model are compiled first.
`timescale 1ns/1ps
module test_event_generator_unit;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [evgen_pkg::NUM_CHANNELS-1:0] chan_in;
   logic [evgen_pkg::NUM_CHANNELS-1:0] chan_out;
   logic irq;
   logic send = 1'b0;
   logic [7:0] send_ch = 8'h00;
   logic [7:0] ch;
   logic [7:0] lc;
   logic [15:0] r;
   logic [15:0] m_flag = 16'h0000;
   logic [15:0] m_mask = 16'h0000;
   int pulse_count;
   int err_count = 0;
   int check_count = 0;

   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end

   event_generator_unit event_generator_unit_inst (.sys_clk(sys_clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .chan_in(chan_in), .chan_out(chan_out), .irq(irq));
   chan_fabric_model chan_fabric_model_inst (.sys_clk(sys_clk), .send(send),
      .send_ch(send_ch), .chan_in(chan_in), .chan_out(chan_out), .pulse_count(pulse_count));

   task automatic check(input string name, input logic [255:0] seen, input logic [255:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      check("reg_rdata", reg_rdata, e);
   endtask

   task automatic pulse(input logic [7:0] c);
      @(posedge sys_clk);
      send <= 1'b1;
      send_ch <= c;
      @(posedge sys_clk);
      send <= 1'b0;
   endtask

   // Interrupt is compared one cycle after the state that causes it.
   task automatic tick();
      @(posedge sys_clk);
      #1;
      check("irq", irq, |(m_flag & m_mask));
   endtask

   initial begin
      repeat (3000) @(posedge sys_clk);
      err_count++;
      stop_test();
   end

   initial begin
      void'($urandom(32'he1ec306a));
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      rd(12'h300, 32'h0);
      rd(12'h100, 32'h0);
      rd(12'h30c, 32'h0);
      $display("reset test done");
      for (int n = 0; n < 16; n++) begin
         // Each task gets its own band of channels so no stale listener fires.
         ch = 8'(16 * n) | 8'($urandom_range(15));
         lc = ch + 8'h01;
         wr(12'h180 + 12'(4 * n), {1'b1, 23'h0, ch});
         rd(12'h180 + 12'(4 * n), {1'b1, 23'h0, ch});
         wr(12'h080 + 12'(4 * n), {n[0], 23'h0, lc});
         rd(12'h080 + 12'(4 * n), {n[0], 23'h0, lc});
         pulse(lc);
         @(posedge sys_clk);
         if (n[0] == 1'b0) begin
            rd(12'h100 + 12'(4 * n), 32'h0);
            wr(12'h000 + 12'(4 * n), 32'h1);
         end
         #1;
         m_flag[n] = 1'b1;
         check("chan_out", chan_out, 256'h1 << ch);
         tick();
         check("chan_out", chan_out, 256'h0);
         rd(12'h100 + 12'(4 * n), 32'h1);
         rd(12'h000 + 12'(4 * n), 32'h0);
      end
      $display("firing test done");
      for (int k = 0; k < 16; k++) begin
         wr(12'h308, 32'hffff_ffff);
         m_mask = 16'h0000;
         tick();
         wr(12'h304, 32'h1 << k);
         m_mask[k] = 1'b1;
         tick();
         wr(12'h304, 32'h0);
         rd(12'h300, 32'h1 << k);
      end
      $display("mask test done");
      r = 16'($urandom()) | 16'h0001;
      wr(12'h300, {16'h0, r});
      m_mask = r;
      tick();
      rd(12'h304, {16'h0, r});
      rd(12'h308, {16'h0, r});
      for (int n = 0; n < 16; n++) begin
         wr(12'h100 + 12'(4 * n), 32'h0);
         m_flag[n] = 1'b0;
         tick();
      end
      wr(12'h000, 32'h0);
      tick();
      wr(12'h114, 32'h1);
      m_flag[5] = 1'b1;
      tick();
      rd(12'h114, 32'h1);
      wr(12'h08c, {1'b1, 23'h0, 8'h05});
      // Clear flag 3 in the very cycle its channel fires it: the firing must win.
      fork
         pulse(8'h05);
         begin
            @(posedge sys_clk);
            wr(12'h10c, 32'h0);
         end
      join
      m_flag[3] = 1'b1;
      rd(12'h10c, 32'h1);
      tick();
      wr(12'h000, 32'h1);
      m_flag[0] = 1'b1;
      tick();
      check("pulse_count", pulse_count, 256'h12);
      $display("interrupt test done");
      stop_test();
   end
endmodule // test_event_generator_unit

// File: core/channel_match.sv
// Compares one listen configuration against the incoming channel events.
// Assumes channel events are one-cycle pulses synchronous to sys_clk.
`timescale 1ns/1ps
module channel_match (
   // Configuration
   input wire evgen_pkg::chan_cfg_t cfg,
   // Channel events
   input wire logic [evgen_pkg::NUM_CHANNELS-1:0] chan_in,
   // Result
   output logic hit
);

   // A disabled listener never fires, whatever its channel carries.
   assign hit = cfg.en && chan_in[cfg.idx];

endmodule // channel_match

// File: core/egu_pkg.sv
// Constants, types and helper functions for the event generator unit.
// Assumes a 32-bit register port with byte addresses and one system clock.
// Summary of operation
// - Sixteen tasks, 0 to 15; firing task n sets event flag n.
// - A task fires from a software write or a hardware channel event.
// - Each instance drives its own interrupt line.
// - All 16 flags share that single interrupt line.
// - Fire registers start at 0x000, one word per task.
// - Channel listen configuration registers start at 0x080, one word per task.
// - Flag registers start at 0x100; a flag sets when its task fires.
// - Channel broadcast configuration registers start at 0x180, one word per flag.
// - Mask registers: direct at 0x300, setter at 0x304, clearer at 0x308.
// - Broadcast config: channel index of 256 and enable; each firing of an enabled task pulses that channel.
// - Interrupt rises one cycle after an enabled flag is set.
package evgen_pkg;

   localparam int NUM_TASKS = 16;
   localparam int NUM_CHANNELS = 256;
   localparam int CHAN_IDX_W = 8;
   localparam int IDX_W = 4;
   localparam int CFG_EN_BIT = 31;

   localparam logic [11:0] STRIDE = 12'h004;
   localparam logic [11:0] SPAN = 12'h040;
   localparam logic [11:0] FIRE_BASE = 12'h000;
   localparam logic [11:0] LISTEN_BASE = 12'h080;
   localparam logic [11:0] FLAG_BASE = 12'h100;
   localparam logic [11:0] BCAST_BASE = 12'h180;
   localparam logic [11:0] MASK_DIRECT = 12'h300;
   localparam logic [11:0] MASK_SETTER = 12'h304;
   localparam logic [11:0] MASK_CLEARER = 12'h308;

   localparam logic [15:0] FLAG_RESET = 16'h0000;
   localparam logic [15:0] MASK_RESET = 16'h0000;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

   typedef struct packed {
      logic en;
      logic [CHAN_IDX_W-1:0] idx;
   } chan_cfg_t;

   localparam chan_cfg_t CFG_RESET = '{en: 1'b0, idx: 8'h00};

   function automatic logic in_region(input logic [11:0] addr, input logic [11:0] base);
      return (addr >= base) && (addr < base + SPAN) && (addr[1:0] == 2'h0);
   endfunction

   function automatic logic [IDX_W-1:0] idx_of(input logic [11:0] addr,
                                                input logic [11:0] base);
      logic [11:0] off;
      off = addr - base;
      return off[IDX_W+1:2];
   endfunction

   function automatic logic [31:0] cfg_word(input chan_cfg_t c);
      return {c.en, 23'h000000, c.idx};
   endfunction

   function automatic chan_cfg_t cfg_from(input logic [31:0] w);
      chan_cfg_t c;
      c.en = w[CFG_EN_BIT];
      c.idx = w[CHAN_IDX_W-1:0];
      return c;
   endfunction

endpackage

// File: core/event_generator_unit.sv
// Event generator unit: sixteen tasks, sixteen sticky flags, one interrupt.
// Assumes a simple register port with one-cycle strobes and a channel
// fabric that delivers and accepts one-cycle event pulses on sys_clk.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module event_generator_unit (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Register port
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Event channel fabric
   input wire logic [evgen_pkg::NUM_CHANNELS-1:0] chan_in,
   output logic [evgen_pkg::NUM_CHANNELS-1:0] chan_out,
   // Interrupt request
   output logic irq
);

   evgen_pkg::chan_cfg_t listen_q [evgen_pkg::NUM_TASKS];
   evgen_pkg::chan_cfg_t bcast_q [evgen_pkg::NUM_TASKS];
   logic [15:0] flag_q;
   logic [15:0] flag_d;
   logic [15:0] mask_q;
   logic [15:0] hw_hit;
   logic [15:0] sw_fire;
   logic [15:0] fire;
   logic [evgen_pkg::NUM_CHANNELS-1:0] chan_out_d;
   logic [evgen_pkg::NUM_CHANNELS-1:0] chan_out_q;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   logic irq_q;
   logic wr_fire;
   logic wr_listen;
   logic wr_flag;
   logic wr_bcast;
   logic [3:0] widx;
   logic [3:0] ridx;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   // Write decode.
   always_comb begin
      wr_fire = 1'b0;
      wr_listen = 1'b0;
      wr_flag = 1'b0;
      wr_bcast = 1'b0;
      widx = 4'h0;
      if (reg_wr && evgen_pkg::in_region(reg_addr, evgen_pkg::FIRE_BASE)) begin
         wr_fire = 1'b1;
         widx = evgen_pkg::idx_of(reg_addr, evgen_pkg::FIRE_BASE);
      end else if (reg_wr && evgen_pkg::in_region(reg_addr, evgen_pkg::LISTEN_BASE)) begin
         wr_listen = 1'b1;
         widx = evgen_pkg::idx_of(reg_addr, evgen_pkg::LISTEN_BASE);
      end else if (reg_wr && evgen_pkg::in_region(reg_addr, evgen_pkg::FLAG_BASE)) begin
         wr_flag = 1'b1;
         widx = evgen_pkg::idx_of(reg_addr, evgen_pkg::FLAG_BASE);
      end else if (reg_wr && evgen_pkg::in_region(reg_addr, evgen_pkg::BCAST_BASE)) begin
         wr_bcast = 1'b1;
         widx = evgen_pkg::idx_of(reg_addr, evgen_pkg::BCAST_BASE);
      end
   end

   // Hardware listeners, one per task.
   for (genvar n = 0; n < evgen_pkg::NUM_TASKS; n++) begin : g_listen
      channel_match u_match (
         .cfg(listen_q[n]),
         .chan_in(chan_in),
         .hit(hw_hit[n])
      );
   end

   // A write of one fires the task; a write of zero is ignored.
   always_comb begin
      sw_fire = 16'h0000;
      if (wr_fire && reg_wdata[0]) begin
         sw_fire[widx] = 1'b1;
      end
   end

   // Both sources merge, so a task fired twice in one cycle counts once.
   assign fire = sw_fire | hw_hit;

   // Flags: a firing in the same cycle as a software clear wins.
   always_comb begin
      flag_d = flag_q;
      if (wr_flag) begin
         flag_d[widx] = reg_wdata[0];
      end
      flag_d = flag_d | fire;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         flag_q <= evgen_pkg::FLAG_RESET;
      end else begin
         flag_q <= flag_d;
      end
   end

   // Listen configuration registers.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         for (int i = 0; i < evgen_pkg::NUM_TASKS; i++) begin
            listen_q[i] <= evgen_pkg::CFG_RESET;
         end
      end else if (wr_listen) begin
         listen_q[widx] <= evgen_pkg::cfg_from(reg_wdata);
      end
   end

   // Broadcast configuration registers.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         for (int i = 0; i < evgen_pkg::NUM_TASKS; i++) begin
            bcast_q[i] <= evgen_pkg::CFG_RESET;
         end
      end else if (wr_bcast) begin
         bcast_q[widx] <= evgen_pkg::cfg_from(reg_wdata);
      end
   end

   // Interrupt mask: direct, set-by-one and clear-by-one views.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mask_q <= evgen_pkg::MASK_RESET;
      end else if (reg_wr && reg_addr == evgen_pkg::MASK_DIRECT) begin
         mask_q <= reg_wdata[15:0];
      end else if (reg_wr && reg_addr == evgen_pkg::MASK_SETTER) begin
         mask_q <= mask_q | reg_wdata[15:0];
      end else if (reg_wr && reg_addr == evgen_pkg::MASK_CLEARER) begin
         mask_q <= mask_q & ~reg_wdata[15:0];
      end
   end

   // Broadcast: every firing with publishing enabled pulses its channel.
   // Several flags may share one channel; their pulses merge into one.
   always_comb begin
      chan_out_d = '0;
      for (int i = 0; i < evgen_pkg::NUM_TASKS; i++) begin
         if (fire[i] && bcast_q[i].en) begin
            chan_out_d[bcast_q[i].idx] = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         chan_out_q <= '0;
      end else begin
         chan_out_q <= chan_out_d;
      end
   end

   assign chan_out = chan_out_q;

   // Interrupt is registered from the flags, costing one cycle of latency
   // but keeping the line glitch free for the interrupt controller.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(flag_q & mask_q);
      end
   end

   assign irq = irq_q;

   // Read decode; unmapped addresses and fire registers read as zero.
   always_comb begin
      rdata_d = 32'h0000_0000;
      ridx = 4'h0;
      if (evgen_pkg::in_region(reg_addr, evgen_pkg::LISTEN_BASE)) begin
         ridx = evgen_pkg::idx_of(reg_addr, evgen_pkg::LISTEN_BASE);
         rdata_d = evgen_pkg::cfg_word(listen_q[ridx]);
      end else if (evgen_pkg::in_region(reg_addr, evgen_pkg::FLAG_BASE)) begin
         ridx = evgen_pkg::idx_of(reg_addr, evgen_pkg::FLAG_BASE);
         rdata_d = {31'h00000000, flag_q[ridx]};
      end else if (evgen_pkg::in_region(reg_addr, evgen_pkg::BCAST_BASE)) begin
         ridx = evgen_pkg::idx_of(reg_addr, evgen_pkg::BCAST_BASE);
         rdata_d = evgen_pkg::cfg_word(bcast_q[ridx]);
      end else if (reg_addr == evgen_pkg::MASK_DIRECT ||
                   reg_addr == evgen_pkg::MASK_SETTER ||
                   reg_addr == evgen_pkg::MASK_CLEARER) begin
         rdata_d = {16'h0000, mask_q};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rdata_q <= evgen_pkg::RDATA_RESET;
      end else if (reg_rd) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= evgen_pkg::RDATA_RESET;
      end
   end

   assign reg_rdata = rdata_q;

   // Checks.

   sequence sw_fire_s;
      reg_wr && reg_addr == evgen_pkg::FIRE_BASE && reg_wdata[0];
   endsequence

   sequence hw_fire_s;
      listen_q[3].en && chan_in[listen_q[3].idx];
   endsequence

   sequence flag_then_irq_s;
      ##1 irq;
   endsequence

   sw_fire_flag_a: assert property (sw_fire_s |=> flag_q[0] ##1 (irq || !$past(mask_q[0])))
      else $error("software fire did not set flag 0");

   hw_fire_flag_a: assert property (hw_fire_s |-> fire[3] ##1 flag_q[3])
      else $error("channel event did not fire task 3");

   listen_off_a: assert property (!listen_q[5].en && !sw_fire[5] |-> !fire[5])
      else $error("disabled listener fired task 5");

   fire_sets_flag_a: assert property (fire != 16'h0000 |=> (flag_q & $past(fire)) == $past(fire))
      else $error("fired task left its flag clear");

   flag_hold_a: assert property (flag_q[2] && !(wr_flag && widx == 4'h2) |=> flag_q[2])
      else $error("flag 2 dropped without a clear");

   irq_latency_a: assert property (|(flag_q & mask_q) |-> flag_then_irq_s)
      else $error("interrupt not raised one cycle after enabled flag");

   irq_quiet_a: assert property (!(|(flag_q & mask_q)) |=> !irq)
      else $error("interrupt raised with no enabled flag");

   mask_set_a: assert property (reg_wr && reg_addr == evgen_pkg::MASK_SETTER
      |=> mask_q == ($past(mask_q) | $past(reg_wdata[15:0])))
      else $error("mask setter did not or in ones");

   mask_clear_a: assert property (reg_wr && reg_addr == evgen_pkg::MASK_CLEARER
      |=> mask_q == ($past(mask_q) & ~$past(reg_wdata[15:0])))
      else $error("mask clearer did not remove ones");

   mask_direct_a: assert property (reg_wr && reg_addr == evgen_pkg::MASK_DIRECT
      |=> mask_q == $past(reg_wdata[15:0]))
      else $error("direct mask write not stored");

   bcast_pulse_a: assert property (fire[0] && bcast_q[0].en
      |=> chan_out[$past(bcast_q[0].idx)])
      else $error("enabled flag 0 did not pulse its channel");

   bcast_idle_a: assert property (fire == 16'h0000 |=> chan_out == '0)
      else $error("channel pulsed with no firing");

   listen_read_a: assert property (reg_rd && reg_addr == evgen_pkg::LISTEN_BASE
      |=> reg_rdata == evgen_pkg::cfg_word($past(listen_q[0])))
      else $error("listen config 0 read back wrong");

   flag_read_a: assert property (reg_rd && reg_addr == evgen_pkg::FLAG_BASE + evgen_pkg::STRIDE
      |=> reg_rdata == {31'h00000000, $past(flag_q[1])})
      else $error("flag 1 read back wrong");

   rdata_idle_a: assert property (!reg_rd
      |=> reg_rdata == evgen_pkg::RDATA_RESET)
      else $error("read data stood outside a read");

   fire_read_a: assert property (reg_rd && reg_addr == evgen_pkg::FIRE_BASE
      |=> reg_rdata == evgen_pkg::RDATA_RESET)
      else $error("fire register read as nonzero");

   setter_read_a: assert property (reg_rd && reg_addr == evgen_pkg::MASK_SETTER
      |=> reg_rdata == {16'h0000, $past(mask_q)})
      else $error("mask setter read back wrong");

   clearer_read_a: assert property (reg_rd && reg_addr == evgen_pkg::MASK_CLEARER
      |=> reg_rdata == {16'h0000, $past(mask_q)})
      else $error("mask clearer read back wrong");

   direct_read_a: assert property (reg_rd && reg_addr == evgen_pkg::MASK_DIRECT
      |=> reg_rdata == {16'h0000, $past(mask_q)})
      else $error("direct mask read back wrong");

   bcast_read_a: assert property (reg_rd && reg_addr == evgen_pkg::BCAST_BASE
      |=> reg_rdata == evgen_pkg::cfg_word($past(bcast_q[0])))
      else $error("broadcast config 0 read back wrong");

   hole_read_a: assert property (reg_rd && reg_addr == evgen_pkg::MASK_CLEARER + evgen_pkg::STRIDE
      |=> reg_rdata == evgen_pkg::RDATA_RESET)
      else $error("unmapped address read as nonzero");

   fire_write_a: assert property (reg_wr && reg_wdata[0]
      && reg_addr == evgen_pkg::FIRE_BASE + (evgen_pkg::STRIDE << 1) |=> flag_q[2])
      else $error("write to fire register 2 did not set flag 2");

   fire_zero_a: assert property (reg_wr && reg_addr == evgen_pkg::FIRE_BASE && !reg_wdata[0]
      |-> !sw_fire[0])
      else $error("write of zero fired task 0");

   listen_write_a: assert property (reg_wr && reg_addr == evgen_pkg::LISTEN_BASE
      |=> listen_q[0] == evgen_pkg::cfg_from($past(reg_wdata)))
      else $error("listen config 0 not stored");

   bcast_write_a: assert property (reg_wr && reg_addr == evgen_pkg::BCAST_BASE
      |=> bcast_q[0] == evgen_pkg::cfg_from($past(reg_wdata)))
      else $error("broadcast config 0 not stored");

   flag_clear_a: assert property (wr_flag && widx == 4'h2 && !reg_wdata[0] && !fire[2]
      |=> !flag_q[2])
      else $error("flag 2 not cleared by a write of zero");

   set_wins_a: assert property (wr_flag && !reg_wdata[0] && fire[widx]
      |=> flag_q[$past(widx)])
      else $error("clear beat a firing in the same cycle");

   flag_write_a: assert property (wr_flag && reg_wdata[0]
      |=> flag_q[$past(widx)])
      else $error("write of one did not set the flag");

   irq_single_a: assert property (flag_q[9] && mask_q[9]
      |=> irq)
      else $error("enabled flag 9 did not raise the interrupt");

   listen_hit_a: assert property (listen_q[7].en && chan_in[listen_q[7].idx]
      |=> flag_q[7])
      else $error("listened channel did not set flag 7");

   mask_clear_irq_a: assert property (reg_wr && reg_addr == evgen_pkg::MASK_CLEARER
      && reg_wdata[15:0] == 16'hffff |=> ##1 !irq)
      else $error("interrupt stayed up after clearing every mask bit");

   mask_hold_a: assert property (!reg_wr
      |=> mask_q == $past(mask_q))
      else $error("mask changed with no write");

   cfg_hold_a: assert property (!wr_listen
      |=> listen_q[0] == $past(listen_q[0]))
      else $error("listen config 0 changed with no write");

endmodule // event_generator_unit
